// >>> hw/opcode_decode.sv
// instruction decoder and cycle sequencer of the accumulator core
// Notes on behaviour
// - instruction cycle is sixteen clocks, one or two
// - 2c adds b into a, conditional status
// - 70 adds 12-bit constant, two bytes, two cycles
// - 63 compares a at least constant
// - 28 adds memory into a, one cycle
// - 65 ands constant into memory, status set
// - 60 tests a differs from constant
// - 68 multiplies a by constant, status set
// - 39 multiplies a by memory, status set
// - 38 multiplies a by timer, status set
// - 40 branches on status, 13-bit target
// - 1f jumps to address in a
// - 6b lookup through a, result to a
// - 6d lookup through a, result to b
// - 64 ors constant into memory, status set
`timescale 1ns/1ns

module opcode_decode
(
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// instruction bytes from program memory
	input  wire logic [7:0]                    fetch_byte,
	input  wire logic                          fetch_valid,
	// execute-stage result flag from the datapath
	input  wire logic                          cond_result,
	// decoded instruction and timing
	output logic                               cycle_strobe,
	output opcode_decode_pkg::decoded_type     decoded,
	output logic                               issue,
	output logic                               operand_fetch,
	output logic                               complete,
	output logic                               status_flag,
	output logic                               branch_taken
);

	////////////////////////////////////////////////////////////////////////////
	// sequencer states
	typedef enum logic [1:0]
	{
		st_opcode  = 2'h0,  // waiting for opcode byte
		st_operand = 2'h1,  // waiting for second byte
		st_second  = 2'h2   // running second instruction cycle
	} seq_type;

	logic [3:0]                        phase;        // clock within instruction cycle
	logic                              cycle_end;    // last clock of cycle
	seq_type                           seq;          // sequencer state
	opcode_decode_pkg::decoded_type    next_decoded; // combinational decode of byte

	assign cycle_end = (phase == opcode_decode_pkg::phase_last);

	////////////////////////////////////////////////////////////////////////////
	// phase counter: sixteen clocks per instruction cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			phase <= opcode_decode_pkg::phase_reset;
		else
			phase <= phase + 4'h1;
	end

	// one-cycle strobe at the last clock of each instruction cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			cycle_strobe <= 1'b0;
		else
			cycle_strobe <= (phase == opcode_decode_pkg::phase_last - 4'h1);
	end

	////////////////////////////////////////////////////////////////////////////
	// opcode decode; bytes are only sampled at cycle end
	always_comb
	begin
		next_decoded = '0;
		next_decoded.known = 1'b1;
		// wide-operand families first: low opcode bits belong to operand
		if ((fetch_byte & opcode_decode_pkg::mask_add_constant) == opcode_decode_pkg::op_add_constant_to_a)
		begin
			next_decoded.oper        = opcode_decode_pkg::oper_add_const;
			next_decoded.status_mode = opcode_decode_pkg::status_conditional;
			next_decoded.two_bytes   = 1'b1;
			next_decoded.two_cycles  = 1'b1;
			next_decoded.operand     = {1'b0, fetch_byte[3:0], 8'h00};
		end
		else if ((fetch_byte & opcode_decode_pkg::mask_long_jump) == opcode_decode_pkg::op_conditional_long_jump)
		begin
			next_decoded.oper        = opcode_decode_pkg::oper_branch;
			next_decoded.status_mode = opcode_decode_pkg::status_always;
			next_decoded.two_bytes   = 1'b1;
			next_decoded.two_cycles  = 1'b1;
			next_decoded.operand     = {fetch_byte[4:0], 8'h00};
		end
		else
		begin
			case (fetch_byte)
				opcode_decode_pkg::op_add_b_into_a:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_add_b;
					next_decoded.status_mode = opcode_decode_pkg::status_conditional;
				end
				opcode_decode_pkg::op_compare_a_at_least_constant:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_cmp_ge;
					next_decoded.status_mode = opcode_decode_pkg::status_conditional;
					next_decoded.two_bytes   = 1'b1;
					next_decoded.two_cycles  = 1'b1;
				end
				opcode_decode_pkg::op_add_memory_into_a:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_add_mem;
					next_decoded.status_mode = opcode_decode_pkg::status_conditional;
				end
				opcode_decode_pkg::op_and_constant_to_memory:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_and_mem;
					next_decoded.status_mode = opcode_decode_pkg::status_always;
					next_decoded.two_bytes   = 1'b1;
					next_decoded.two_cycles  = 1'b1;
				end
				opcode_decode_pkg::op_compare_a_differs_constant:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_cmp_ne;
					next_decoded.status_mode = opcode_decode_pkg::status_conditional;
					next_decoded.two_bytes   = 1'b1;
					next_decoded.two_cycles  = 1'b1;
				end
				opcode_decode_pkg::op_multiply_a_by_constant:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_mul_const;
					next_decoded.status_mode = opcode_decode_pkg::status_always;
					next_decoded.two_bytes   = 1'b1;
					next_decoded.two_cycles  = 1'b1;
				end
				opcode_decode_pkg::op_multiply_a_by_memory:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_mul_mem;
					next_decoded.status_mode = opcode_decode_pkg::status_always;
				end
				opcode_decode_pkg::op_multiply_a_by_timer:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_mul_timer;
					next_decoded.status_mode = opcode_decode_pkg::status_always;
				end
				opcode_decode_pkg::op_jump_via_accumulator:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_jump_a;
					next_decoded.status_mode = opcode_decode_pkg::status_always;
				end
				opcode_decode_pkg::op_lookup_into_accumulator:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_lookup_a;
					next_decoded.status_mode = opcode_decode_pkg::status_always;
					next_decoded.two_cycles  = 1'b1;
				end
				opcode_decode_pkg::op_lookup_into_second_reg:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_lookup_b;
					next_decoded.status_mode = opcode_decode_pkg::status_always;
					next_decoded.two_cycles  = 1'b1;
				end
				opcode_decode_pkg::op_or_constant_to_memory:
				begin
					next_decoded.oper        = opcode_decode_pkg::oper_or_mem;
					next_decoded.status_mode = opcode_decode_pkg::status_always;
					next_decoded.two_bytes   = 1'b1;
					next_decoded.two_cycles  = 1'b1;
				end
				// outside this decoder: one-cycle no-op, status kept
				default:
					next_decoded.known = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer and decoded register; one- or two-cycle instructions
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			seq           <= st_opcode;
			decoded       <= '0;
			issue         <= 1'b0;
			operand_fetch <= 1'b0;
			complete      <= 1'b0;
		end
		else
		begin
			issue         <= 1'b0;
			operand_fetch <= 1'b0;
			complete      <= 1'b0;
			if (cycle_end)
			begin
				case (seq)
					st_opcode:
					begin
						if (fetch_valid)
						begin
							decoded <= next_decoded;
							issue   <= 1'b1;
							if (next_decoded.two_bytes)
								seq <= st_operand;
							else if (next_decoded.two_cycles)
								seq <= st_second;
							else
								complete <= 1'b1;
						end
					end
					st_operand:
					begin
						// second byte holds the operand low bits
						if (fetch_valid)
						begin
							decoded.operand <= decoded.operand | {5'h00, fetch_byte};
							operand_fetch   <= 1'b1;
							complete        <= 1'b1;
							seq             <= st_opcode;
						end
					end
					st_second:
					begin
						complete <= 1'b1;
						seq      <= st_opcode;
					end
					default:
						seq <= st_opcode;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status flag and branch decision at completion
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			status_flag  <= 1'b1;
			branch_taken <= 1'b0;
		end
		else
		begin
			branch_taken <= 1'b0;
			if (complete)
			begin
				// branch taken only while status set
				if (decoded.oper == opcode_decode_pkg::oper_branch)
					branch_taken <= status_flag;
				if (decoded.status_mode == opcode_decode_pkg::status_always)
					status_flag <= 1'b1;
				else if (decoded.status_mode == opcode_decode_pkg::status_conditional)
					status_flag <= cond_result;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	// phase counter rolls over after the last clock of a cycle
	a_phase_wraps: assert property (@(posedge clk) disable iff (rst)
		cycle_end |=> (phase == 4'h0)) else $error("phase did not wrap");
	// strobe marks only the last clock of a cycle
	a_strobe_at_end: assert property (@(posedge clk) disable iff (rst)
		cycle_strobe |-> cycle_end) else $error("strobe off cycle end");
	// completion lands on an instruction-cycle boundary
	a_complete_on_boundary: assert property (@(posedge clk) disable iff (rst)
		complete |-> (phase == 4'h0)) else $error("completion off boundary");
	// one-byte one-cycle work, unknown opcodes too, ends in the issue clock
	a_short_one_cycle: assert property (@(posedge clk) disable iff (rst)
		(issue && !decoded.two_bytes && !decoded.two_cycles) |-> complete)
		else $error("one-cycle instruction late");
	// always-set instructions leave status true whatever the datapath says
	a_always_sets_status: assert property (@(posedge clk) disable iff (rst)
		(complete && decoded.status_mode == opcode_decode_pkg::status_always) |=> status_flag)
		else $error("status not forced");
	// conditional instructions copy the datapath result of the completion clock
	a_cond_status: assert property (@(posedge clk) disable iff (rst)
		(complete && decoded.status_mode == opcode_decode_pkg::status_conditional) |=> (status_flag == $past(cond_result)))
		else $error("conditional status wrong");
	// lookup into a spends a second instruction cycle
	a_lookup_two_cycles: assert property (@(posedge clk) disable iff (rst)
		(issue && decoded.oper == opcode_decode_pkg::oper_lookup_a) |-> ##16 complete)
		else $error("lookup not two cycles");
	// lookup into b: not done at issue, done one instruction cycle later
	a_lookup_b_cycles: assert property (@(posedge clk) disable iff (rst)
		(issue && decoded.oper == opcode_decode_pkg::oper_lookup_b) |-> !complete ##16 complete)
		else $error("lookup b not two cycles");
	// add b into a finishes in its own cycle
	a_one_cycle_add: assert property (@(posedge clk) disable iff (rst)
		(issue && decoded.oper == opcode_decode_pkg::oper_add_b) |-> complete)
		else $error("add b not one cycle");
	// the second byte is only ever taken by a two-byte instruction as it ends
	a_operand_with_end: assert property (@(posedge clk) disable iff (rst)
		operand_fetch |-> (complete && decoded.two_bytes))
		else $error("operand byte off completion");
	// a branch is only reported while status was set
	a_branch_needs_status: assert property (@(posedge clk) disable iff (rst)
		branch_taken |-> $past(status_flag)) else $error("branch without status");
	// a branch leaves status set afterwards, taken or not
	a_branch_leaves_set: assert property (@(posedge clk) disable iff (rst)
		(complete && decoded.oper == opcode_decode_pkg::oper_branch) |=> status_flag)
		else $error("branch left status clear");
	// timer multiply forces status in the clock after it ends
	a_timer_mul_status: assert property (@(posedge clk) disable iff (rst)
		(issue && decoded.oper == opcode_decode_pkg::oper_mul_timer) |=> status_flag)
		else $error("timer multiply status");

endmodule : opcode_decode

// >>> inc/opcode_decode_pkg.sv
// shared constants and types of the instruction decoder
package opcode_decode_pkg;

	// clocks per instruction cycle
	localparam int unsigned clocks_per_cycle = 16;
	localparam logic [3:0]  phase_last       = 4'hf;
	localparam logic [3:0]  phase_reset      = 4'h0;

	// opcode encodings
	localparam logic [7:0] op_add_b_into_a               = 8'h2c;
	localparam logic [7:0] op_add_constant_to_a          = 8'h70;
	localparam logic [7:0] op_compare_a_at_least_constant = 8'h63;
	localparam logic [7:0] op_add_memory_into_a          = 8'h28;
	localparam logic [7:0] op_and_constant_to_memory     = 8'h65;
	localparam logic [7:0] op_compare_a_differs_constant = 8'h60;
	localparam logic [7:0] op_multiply_a_by_constant     = 8'h68;
	localparam logic [7:0] op_multiply_a_by_memory       = 8'h39;
	localparam logic [7:0] op_multiply_a_by_timer        = 8'h38;
	localparam logic [7:0] op_conditional_long_jump      = 8'h40;
	localparam logic [7:0] op_jump_via_accumulator       = 8'h1f;
	localparam logic [7:0] op_lookup_into_accumulator    = 8'h6b;
	localparam logic [7:0] op_lookup_into_second_reg     = 8'h6d;
	localparam logic [7:0] op_or_constant_to_memory      = 8'h64;

	// opcode masks for families whose low opcode bits carry operand
	localparam logic [7:0] mask_add_constant = 8'hf0;
	localparam logic [7:0] mask_long_jump    = 8'he0;

	// operand widths in bits
	localparam int unsigned width_add_constant = 12;
	localparam int unsigned width_long_jump    = 13;
	localparam int unsigned width_byte_operand = 8;

	// operation classes
	typedef enum logic [3:0]
	{
		oper_none        = 4'h0,
		oper_add_b       = 4'h1,
		oper_add_const   = 4'h2,
		oper_cmp_ge      = 4'h3,
		oper_add_mem     = 4'h4,
		oper_and_mem     = 4'h5,
		oper_cmp_ne      = 4'h6,
		oper_mul_const   = 4'h7,
		oper_mul_mem     = 4'h8,
		oper_mul_timer   = 4'h9,
		oper_branch      = 4'ha,
		oper_jump_a      = 4'hb,
		oper_lookup_a    = 4'hc,
		oper_lookup_b    = 4'hd,
		oper_or_mem      = 4'he
	} oper_type;

	// how an instruction treats the status flag
	typedef enum logic [1:0]
	{
		status_keep        = 2'h0,
		status_always      = 2'h1,
		status_conditional = 2'h2
	} status_mode_type;

	// decoded instruction carried to the execute stage
	typedef struct packed
	{
		oper_type        oper;
		status_mode_type status_mode;
		logic            two_bytes;
		logic            two_cycles;
		logic [12:0]     operand;
		logic            known;
	} decoded_type;

endpackage : opcode_decode_pkg

// >>> verif/prog_mem_model.sv
// program memory model feeding instruction bytes to the decoder
`timescale 1ns/1ns

module prog_mem_model
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// fetch timing from the core and control from the bench
	input  wire logic       cycle_strobe,
	input  wire logic       stall,
	input  wire logic [7:0] next_byte,
	// byte lane towards the core
	output logic [7:0]      fetch_byte,
	output logic            fetch_valid
);

	////////////////////////////////////////////////////////////////
	// present a byte only in the last clock of an instruction cycle
	// outside that clock the lane toggles so a stale value cannot pass for a fetch
	always @(negedge clk)
	begin
		if (!rst && cycle_strobe === 1'b1 && !stall)
		begin
			fetch_byte  <= next_byte;  // slot of the fetch
			fetch_valid <= 1'b1;
		end
		else
		begin
			fetch_byte  <= ~fetch_byte;  // changing pattern, no hold time
			fetch_valid <= 1'b0;  // stalled or between fetch slots
		end
	end

	// defined lane from time zero
	initial
	begin
		fetch_byte  = 8'h5a;
		fetch_valid = 1'b0;
	end

endmodule : prog_mem_model

// >>> verif/speech_cpu_opcode_decode_test.sv
// self-checking bench of the instruction decoder
`timescale 1ns/1ns

module speech_cpu_opcode_decode_test;

	logic                           clk;           // 25 MHz core clock
	logic                           rst;           // sync reset
	logic                           cond_result;   // datapath condition
	logic                           stall;         // memory not ready
	logic [7:0]                     next_byte;     // byte for next fetch slot
	logic [7:0]                     fetch_byte;    // lane to the core
	logic                           fetch_valid;   // lane qualifier
	logic                           cycle_strobe;  // last clock of a cycle
	opcode_decode_pkg::decoded_type decoded;       // decoded instruction
	logic                           issue;         // opcode taken
	logic                           operand_fetch; // second byte taken
	logic                           complete;      // instruction done
	logic                           status_flag;   // status flag
	logic                           branch_taken;  // branch went
	int                             err_count;     // mismatches
	int                             samples_checked; // comparisons
	logic                           exp_status;    // bench copy of status

	////////////////////////////////////////////////////////////////
	// clock and instances
	always #20 clk = ~clk;

	opcode_decode i_dut
	(
		.clk(clk), .rst(rst), .fetch_byte(fetch_byte), .fetch_valid(fetch_valid),
		.cond_result(cond_result), .cycle_strobe(cycle_strobe), .decoded(decoded),
		.issue(issue), .operand_fetch(operand_fetch), .complete(complete),
		.status_flag(status_flag), .branch_taken(branch_taken)
	);

	prog_mem_model i_mem
	(
		.clk(clk), .rst(rst), .cycle_strobe(cycle_strobe), .stall(stall),
		.next_byte(next_byte), .fetch_byte(fetch_byte), .fetch_valid(fetch_valid)
	);

	////////////////////////////////////////////////////////////////
	// reporting
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// a bound that runs out ends the run at once
	task automatic timed_out(input string what);
		err_count++;
		$display("[ERR] %s timed out", what);
		end_of_test();
	endtask : timed_out

	////////////////////////////////////////////////////////////////
	// one instruction from fetch to status update; shape is {two_bytes, two_cycles}
	task automatic exec(input logic [7:0] op, input logic [7:0] b2, input logic [3:0] oper,
		input logic [1:0] sm, input logic [1:0] shape, input logic [12:0] opnd, input logic cr);
		int  n;
		logic br;
		br          = (oper == 4'ha) && exp_status;  // decision uses status before completion
		next_byte   = op;
		cond_result = cr;
		n           = 0;
		while (issue !== 1'b1)
		begin
			@(negedge clk);
			n++;
			if (n > 40)
				timed_out("issue");
		end
		check("oper", {12'h000, decoded.oper}, {12'h000, oper});
		check("status_mode", {14'h0000, decoded.status_mode}, {14'h0000, sm});
		check("shape", {14'h0000, decoded.two_bytes, decoded.two_cycles}, {14'h0000, shape});
		check("known", {15'h0000, decoded.known}, {15'h0000, oper != 4'h0});
		next_byte = b2;  // second byte goes into the following fetch slot
		n         = 0;
		while (complete !== 1'b1)
		begin
			@(negedge clk);
			n++;
			if (n > 20)
				timed_out("complete");
		end
		check("cycles", n[15:0], shape[0] ? 16'(opcode_decode_pkg::clocks_per_cycle) : 16'h0000);
		check("operand_fetch", {15'h0000, operand_fetch}, {15'h0000, shape[1]});
		if (shape[1])
			check("operand", {3'h0, decoded.operand}, {3'h0, opnd});
		@(negedge clk);
		if (sm == 2'h2)
			exp_status = cr;  // conditional status follows the datapath
		else if (sm == 2'h1)
			exp_status = 1'b1;  // always-set forces true
		check("status_flag", {15'h0000, status_flag}, {15'h0000, exp_status});
		check("branch_taken", {15'h0000, branch_taken}, {15'h0000, br});
	endtask : exec

	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic test_reset;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		check("reset_status", {15'h0000, status_flag}, 16'h0001);
		check("reset_issue", {15'h0000, issue | complete | branch_taken}, 16'h0000);
		rst        = 1'b0;
		exp_status = 1'b1;
		$display("test reset done");
	endtask : test_reset

	// every listed opcode except the 40 branch back to back, wide operands split across bytes
	task automatic test_decode;
		exec(8'h2c, 8'h00, 4'h1, 2'h2, 2'h0, 13'h0000, 1'b0);
		exec(8'h7a, 8'h34, 4'h2, 2'h2, 2'h3, 13'h0a34, 1'b1);
		exec(8'h63, 8'h80, 4'h3, 2'h2, 2'h3, 13'h0080, 1'b0);
		exec(8'h28, 8'h00, 4'h4, 2'h2, 2'h0, 13'h0000, 1'b1);
		exec(8'h65, 8'h0f, 4'h5, 2'h1, 2'h3, 13'h000f, 1'b0);
		exec(8'h60, 8'h55, 4'h6, 2'h2, 2'h3, 13'h0055, 1'b0);
		exec(8'h68, 8'hff, 4'h7, 2'h1, 2'h3, 13'h00ff, 1'b0);
		exec(8'h39, 8'h00, 4'h8, 2'h1, 2'h0, 13'h0000, 1'b0);
		exec(8'h38, 8'h00, 4'h9, 2'h1, 2'h0, 13'h0000, 1'b0);
		exec(8'h1f, 8'h00, 4'hb, 2'h1, 2'h0, 13'h0000, 1'b0);
		exec(8'h6b, 8'h00, 4'hc, 2'h1, 2'h1, 13'h0000, 1'b0);
		exec(8'h6d, 8'h00, 4'hd, 2'h1, 2'h1, 13'h0000, 1'b0);
		exec(8'h64, 8'h81, 4'he, 2'h1, 2'h3, 13'h0081, 1'b0);
		$display("test decode done");
	endtask : test_decode

	// branch refused on clear status, taken on set status; unknown opcode keeps status
	task automatic test_branch;
		exec(8'h2c, 8'h00, 4'h1, 2'h2, 2'h0, 13'h0000, 1'b0);
		exec(8'h2f, 8'h00, 4'h0, 2'h0, 2'h0, 13'h0000, 1'b1); // unknown opcode
		exec(8'h5f, 8'h12, 4'ha, 2'h1, 2'h3, 13'h1f12, 1'b0);
		exec(8'h40, 8'h00, 4'ha, 2'h1, 2'h3, 13'h0000, 1'b0);
		$display("test branch done");
	endtask : test_branch

	// memory stalls two fetch slots: nothing is taken, strobe keeps its sixteen-clock beat
	task automatic test_stall;
		int strobes;
		int issues;
		strobes   = 0;
		issues    = 0;
		stall     = 1'b1;
		next_byte = 8'h39;
		repeat (32)
		begin
			@(negedge clk);
			strobes += (cycle_strobe === 1'b1);
			issues  += (issue === 1'b1);
		end
		check("strobes", strobes[15:0], 16'h0002);
		check("refused", issues[15:0], 16'h0000);
		stall = 1'b0;
		exec(8'h39, 8'h00, 4'h8, 2'h1, 2'h0, 13'h0000, 1'b0);
		$display("test stall done");
	endtask : test_stall

	// reset in the middle of a two-cycle lookup: no stale completion, status back to set
	task automatic test_reset_mid;
		int n;
		exec(8'h2c, 8'h00, 4'h1, 2'h2, 2'h0, 13'h0000, 1'b0);
		next_byte = 8'h6b;
		n         = 0;
		while (issue !== 1'b1)
		begin
			@(negedge clk);
			n++;
			if (n > 40)
				timed_out("mid issue");
		end
		repeat (4) @(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		check("mid_status", {15'h0000, status_flag}, 16'h0001);
		check("mid_pulses", {15'h0000, issue | complete | branch_taken}, 16'h0000);
		// memory held off so that only a leftover completion could show up
		rst   = 1'b0;
		stall = 1'b1;
		n     = 0;
		repeat (16)
		begin
			@(negedge clk);
			n += (complete === 1'b1);
		end
		check("mid_complete", n[15:0], 16'h0000);
		stall      = 1'b0;
		exp_status = 1'b1;
		exec(8'h6b, 8'h00, 4'hc, 2'h1, 2'h1, 13'h0000, 1'b0);
		$display("test reset mid done");
	endtask : test_reset_mid

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		clk             = 1'b0;
		rst             = 1'b1;
		cond_result     = 1'b0;
		stall           = 1'b0;
		next_byte       = 8'h00;
		err_count       = 0;
		samples_checked = 0;
		exp_status      = 1'b1;
		test_reset();
		test_decode();
		test_branch();
		test_stall();
		test_reset_mid();
		end_of_test();
	end

endmodule : speech_cpu_opcode_decode_test
